// >>> hw/rtcmb_pkg.sv
/*
 Package for the multiplexed-bus clock/calendar host port: sizes, map bounds,
 timing constants and carrier structs.
 Assumes a single 250 MHz clock domain in every user.
*/
`default_nettype none
package rtcmb_pkg;
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned FIXED_OUT_HZ = 32768;
    localparam int unsigned FIXED_HALF_CYC = CLK_HZ / (2 * FIXED_OUT_HZ);
    localparam int unsigned WIPE_MIN_MS = 125;
    localparam int unsigned WIPE_MIN_CYC = (CLK_HZ / 1000) * WIPE_MIN_MS;
    localparam int unsigned SEC_CYC = CLK_HZ;
    localparam int unsigned CLK_REGS = 14;
    localparam int unsigned STORE_LO = 242;
    localparam int unsigned STORE_HI = 128;
    localparam int unsigned MEM_AW = 9;
    localparam int unsigned MEM_WORDS = 384;
    localparam logic [7:0] ADDR_SEC = 8'h00;
    localparam logic [7:0] ADDR_SEC_ALM = 8'h01;
    localparam logic [7:0] ADDR_MIN = 8'h02;
    localparam logic [7:0] ADDR_MIN_ALM = 8'h03;
    localparam logic [7:0] ADDR_HR = 8'h04;
    localparam logic [7:0] ADDR_HR_ALM = 8'h05;
    localparam logic [7:0] ADDR_CTRL_B = 8'h0B;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_CTRL_D = 8'h0D;
    localparam logic [7:0] ADDR_STORE0 = 8'h0E;
    localparam int unsigned EN_PIE = 6;
    localparam int unsigned EN_AIE = 5;
    localparam int unsigned EN_UIE = 4;
    localparam int unsigned FLG_ANY = 7;
    localparam logic [7:0] CTRL_B_RST = 8'h02;
    localparam logic [7:0] WIPE_VAL = 8'hFF;

    typedef struct packed {
        logic style_ds;
        logic addr_strobe;
        logic data_strobe;
        logic dir_wr;
        logic cs_n;
        logic upper_ram_select;
        logic [7:0] mux_addr_data;
    } rtcmb_bus_s;

    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [7:0] wdata;
    } rtcmb_mem_s;

    typedef enum logic [1:0] {
        RTCMB_IDLE = 2'b00,
        RTCMB_READ = 2'b01,
        RTCMB_WIPE = 2'b10
    } rtcmb_state_e;
endpackage
`default_nettype wire

// >>> hw/rtcmb_mem.sv
/*
 Storage memory for general bytes and the extended bank.
 Assumes one-cycle registered read, single port.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmb_mem #(
    parameter int unsigned AW = 9,
    parameter int unsigned WORDS = 384
) (
    input wire logic clock_i,
    input wire rtcmb_pkg::rtcmb_mem_s req_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_ff [WORDS];
    logic [7:0] rdata_ff;

    always_ff @(posedge clock_i) begin
        if (req_i.we) begin
            mem_ff[req_i.addr] <= req_i.wdata;
        end
        rdata_ff <= mem_ff[req_i.addr];
    end
    assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// >>> hw/rtcmb_port.sv
/*
 Device side of the multiplexed-bus clock/calendar: address latch, both strobe
 styles, clock registers, event flags, open-drain interrupt, storage wipe of the general bytes (not the extended bank),
 fixed clock output and power-fail write block for time registers and storage (control B writes still pass).
 Assumes bus pins are asynchronous to clock_i; supply good is a level pin.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmb_port #(
    parameter int unsigned WIPE_CYC = rtcmb_pkg::WIPE_MIN_CYC,
    parameter int unsigned SEC_CYC = rtcmb_pkg::SEC_CYC
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire rtcmb_pkg::rtcmb_bus_s bus_i,
    input wire logic rst_n_i,
    input wire logic ram_wipe_n_i,
    input wire logic supply_ok_i,
    output logic [7:0] mux_addr_data_o,
    output logic mux_addr_data_oe_o,
    output logic irq_n_o,
    output logic irq_oe_o,
    output logic fixed_clock_out_o,
    output logic wipe_busy_o
);
    localparam int unsigned SW = $bits(rtcmb_pkg::rtcmb_bus_s) + 3;
    // Two-stage sync of every pin; stage one read only by stage two
    logic [SW-1:0] s1_ff, s2_ff;
    logic [SW-4:0] s3_ff;
    always_ff @(posedge clock_i) begin
        s1_ff <= {bus_i, rst_n_i, ram_wipe_n_i, supply_ok_i};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff[SW-1:3];
    end
    rtcmb_pkg::rtcmb_bus_s b, bp;
    logic rstn, wipen, vok;
    assign {b, rstn, wipen, vok} = s2_ff;
    assign bp = s3_ff;

    wire as_fall = bp.addr_strobe & ~b.addr_strobe;
    wire ds_rise = ~bp.data_strobe & b.data_strobe;
    wire ds_fall = bp.data_strobe & ~b.data_strobe;
    wire rw_rise = ~bp.dir_wr & b.dir_wr;
    wire sel = ~b.cs_n & rstn;
    // Strap picks the strobe style
    wire rd_start = sel & (b.style_ds ? (ds_rise & b.dir_wr) : ds_fall);
    wire wr_take = sel & (b.style_ds ? (ds_fall & ~b.dir_wr) : rw_rise);
    wire rd_end = b.style_ds ? ds_fall : (~bp.data_strobe & b.data_strobe);
    wire wr_ok = wr_take & vok;

    logic [7:0] addr_ff, nxt_addr;
    logic upper_ff, nxt_upper;
    always_comb begin
        nxt_addr = addr_ff;
        nxt_upper = upper_ff;
        if (as_fall) begin
            nxt_addr = b.mux_addr_data;
            nxt_upper = b.upper_ram_select;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            addr_ff <= 8'h00;
            upper_ff <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            upper_ff <= nxt_upper;
        end
    end

    // Register file: time, alarm, controls, flags
    logic [7:0] tm_ff [6], nxt_tm [6];
    logic [7:0] ctlb_ff, nxt_ctlb;
    logic [7:0] flg_ff, nxt_flg;
    logic [27:0] sec_ff, nxt_sec;
    wire is_reg = ~upper_ff && addr_ff < 8'(rtcmb_pkg::CLK_REGS);
    wire tick = sec_ff == 28'(SEC_CYC - 1);
    wire alarm_hit = tm_ff[0] == tm_ff[1] && tm_ff[2] == tm_ff[3] && tm_ff[4] == tm_ff[5];
    wire rd_flags = rd_start & is_reg & addr_ff == rtcmb_pkg::ADDR_FLAGS;
    logic [2:0] evt;
    always_comb begin
        nxt_sec = tick ? 28'h0 : sec_ff + 28'h1;
        for (int i = 0; i < 6; i++) begin
            nxt_tm[i] = tm_ff[i];
        end
        // Binary seconds/minutes/hours roll once per second
        if (tick) begin
            nxt_tm[0] = (tm_ff[0] == 8'h3B) ? 8'h00 : tm_ff[0] + 8'h01;
            if (tm_ff[0] == 8'h3B) begin
                nxt_tm[2] = (tm_ff[2] == 8'h3B) ? 8'h00 : tm_ff[2] + 8'h01;
                if (tm_ff[2] == 8'h3B) begin
                    nxt_tm[4] = (tm_ff[4] == 8'h17) ? 8'h00 : tm_ff[4] + 8'h01;
                end
            end
        end
        nxt_ctlb = ctlb_ff;
        if (wr_ok & is_reg & addr_ff < 8'h06) begin
            nxt_tm[addr_ff[2:0]] = b.mux_addr_data;
        end
        if (wr_take & is_reg & addr_ff == rtcmb_pkg::ADDR_CTRL_B) begin
            nxt_ctlb = b.mux_addr_data;
        end
        // Alarm keeps flagging regardless of supply
        evt = {1'b0, tick & alarm_hit, tick};
        nxt_flg = flg_ff;
        if (rd_flags) begin
            nxt_flg = 8'h00;
        end
        nxt_flg[6:4] = nxt_flg[6:4] | evt;
        if ((nxt_flg[6:4] & ctlb_ff[6:4]) != 3'b000) begin
            nxt_flg[rtcmb_pkg::FLG_ANY] = 1'b1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sec_ff <= 28'h0;
            for (int i = 0; i < 6; i++) begin
                tm_ff[i] <= 8'h00;
            end
            ctlb_ff <= rtcmb_pkg::CTRL_B_RST;
            flg_ff <= 8'h00;
        end else begin
            sec_ff <= nxt_sec;
            tm_ff <= nxt_tm;
            // Reset pin clears enables; left alone they persist
            ctlb_ff <= rstn ? nxt_ctlb : (nxt_ctlb & 8'h8F);
            flg_ff <= rstn ? nxt_flg : 8'h00;
        end
    end

    // Interrupt pin, open-drain
    logic irq_ff, nxt_irq;
    always_comb begin
        nxt_irq = (nxt_flg[6:4] & nxt_ctlb[6:4]) != 3'b000;
        if (rd_flags | ~rstn) begin
            nxt_irq = 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end
    assign irq_n_o = 1'b0;
    assign irq_oe_o = irq_ff;

    // Wipe qualification and sweep
    rtcmb_pkg::rtcmb_state_e st_ff, nxt_st;
    logic [31:0] wcnt_ff, nxt_wcnt;
    logic [8:0] wptr_ff, nxt_wptr;
    logic drv_ff, nxt_drv;
    logic [7:0] reg_rd;
    logic [7:0] mem_rd;
    rtcmb_pkg::rtcmb_mem_s mreq;
    always_comb begin
        nxt_st = st_ff;
        nxt_wptr = wptr_ff;
        nxt_drv = drv_ff;
        nxt_wcnt = (~wipen & vok) ? wcnt_ff + 32'h1 : 32'h0;
        mreq.we = 1'b0;
        mreq.wdata = b.mux_addr_data;
        mreq.addr = upper_ff ? 9'(rtcmb_pkg::STORE_LO) + {2'b00, addr_ff[6:0]}
                             : {1'b0, addr_ff - rtcmb_pkg::ADDR_STORE0};
        case (st_ff)
            rtcmb_pkg::RTCMB_IDLE: begin
                if (wcnt_ff == 32'(WIPE_CYC)) begin
                    nxt_st = rtcmb_pkg::RTCMB_WIPE;
                    nxt_wptr = 9'h0;
                end else if (rd_start) begin
                    nxt_st = rtcmb_pkg::RTCMB_READ;
                end else if (wr_ok & ~is_reg) begin
                    mreq.we = 1'b1;
                end
            end
            rtcmb_pkg::RTCMB_READ: begin
                nxt_drv = 1'b1;
                if (rd_end | ~sel) begin
                    nxt_drv = 1'b0;
                    nxt_st = rtcmb_pkg::RTCMB_IDLE;
                end
            end
            rtcmb_pkg::RTCMB_WIPE: begin
                mreq.we = 1'b1;
                mreq.addr = wptr_ff;
                mreq.wdata = rtcmb_pkg::WIPE_VAL;
                nxt_wptr = wptr_ff + 9'h1;
                if (wptr_ff == 9'(rtcmb_pkg::STORE_LO - 1)) begin
                    nxt_st = rtcmb_pkg::RTCMB_IDLE;
                end
            end
            default: nxt_st = rtcmb_pkg::RTCMB_IDLE;
        endcase
        if (wipen) begin
            nxt_wcnt = 32'h0;
        end else if (wcnt_ff > 32'(WIPE_CYC)) begin
            nxt_wcnt = wcnt_ff;
        end else if (wcnt_ff == 32'(WIPE_CYC) && st_ff != rtcmb_pkg::RTCMB_IDLE) begin
            // Accepted wipe waits out a read in progress
            nxt_wcnt = wcnt_ff;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= rtcmb_pkg::RTCMB_IDLE;
            wcnt_ff <= 32'h0;
            wptr_ff <= 9'h0;
            drv_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            wcnt_ff <= nxt_wcnt;
            wptr_ff <= nxt_wptr;
            drv_ff <= nxt_drv;
        end
    end

    rtcmb_mem #(
        .AW(rtcmb_pkg::MEM_AW),
        .WORDS(rtcmb_pkg::MEM_WORDS)
    ) u_mem (
        .clock_i(clock_i),
        .req_i(mreq),
        .rdata_o(mem_rd)
    );

    always_comb begin
        reg_rd = 8'h00;
        if (addr_ff < 8'h06) begin
            reg_rd = tm_ff[addr_ff[2:0]];
        end else if (addr_ff == rtcmb_pkg::ADDR_CTRL_B) begin
            reg_rd = ctlb_ff;
        end else if (addr_ff == rtcmb_pkg::ADDR_FLAGS) begin
            reg_rd = flg_ff;
        end else if (addr_ff == rtcmb_pkg::ADDR_CTRL_D) begin
            reg_rd = {vok, 7'h00};
        end
    end
    logic [7:0] dout_ff;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            dout_ff <= 8'h00;
        end else if (rd_start) begin
            dout_ff <= (addr_ff == rtcmb_pkg::ADDR_FLAGS && is_reg) ? flg_ff : reg_rd;
        end else if (st_ff == rtcmb_pkg::RTCMB_READ && ~drv_ff && ~is_reg) begin
            dout_ff <= mem_rd;
        end
    end
    assign mux_addr_data_o = dout_ff;
    assign mux_addr_data_oe_o = drv_ff;

    // Fixed divider, no register control reaches it; supply loss holds its output low
    logic [11:0] div_ff, nxt_div;
    logic fck_ff, nxt_fck;
    always_comb begin
        nxt_div = div_ff + 12'h1;
        nxt_fck = fck_ff;
        if (div_ff == 12'(rtcmb_pkg::FIXED_HALF_CYC - 1)) begin
            nxt_div = 12'h0;
            nxt_fck = ~fck_ff;
        end
        if (~vok) begin
            nxt_fck = 1'b0;
        end
    end
    logic busy_ff;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            div_ff <= 12'h0;
            fck_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            fck_ff <= nxt_fck;
            busy_ff <= nxt_st == rtcmb_pkg::RTCMB_WIPE;
        end
    end
    assign fixed_clock_out_o = fck_ff;
    assign wipe_busy_o = busy_ff;

    a_irq_release: assert property (@(posedge clock_i) disable iff (srst_i)
        rd_flags |=> !irq_oe_o) else $error("interrupt not released on flag read");
    a_flag_clear: assert property (@(posedge clock_i) disable iff (srst_i)
        rd_flags && !tick |=> flg_ff[7] == 1'b0) else $error("flags not cleared");
    a_rst_quiet: assert property (@(posedge clock_i) disable iff (srst_i)
        !rstn |=> !irq_oe_o) else $error("interrupt asserted in reset");
    a_pf_block: assert property (@(posedge clock_i) disable iff (srst_i)
        !vok && !tick && st_ff == rtcmb_pkg::RTCMB_IDLE
        |-> !mreq.we ##1 tm_ff[0] == $past(tm_ff[0])) else $error("write in power fail");
    a_fix_toggle: assert property (@(posedge clock_i) disable iff (srst_i)
        $changed(fixed_clock_out_o) && vok && $past(vok)
        |-> $past(div_ff) == 12'(rtcmb_pkg::FIXED_HALF_CYC - 1))
        else $error("fixed clock period wrong");
    a_wipe_entry: assert property (@(posedge clock_i) disable iff (srst_i)
        st_ff != rtcmb_pkg::RTCMB_WIPE ##1 st_ff == rtcmb_pkg::RTCMB_WIPE
        |-> $past(wcnt_ff) == 32'(WIPE_CYC)) else $error("wipe started early");
    a_irq_cause: assert property (@(posedge clock_i) disable iff (srst_i)
        irq_oe_o |-> (flg_ff[6:4] & ctlb_ff[6:4]) != 3'b000) else $error("irq without cause");
    a_addr_latch: assert property (@(posedge clock_i) disable iff (srst_i)
        as_fall |=> addr_ff == $past(b.mux_addr_data)) else $error("address not latched");
endmodule
`default_nettype wire

// >>> tb/rtcmb_tb_host.sv
/*
 Host processor model for the multiplexed clock/calendar bus.
 Assumes the bench resolves the shared lines from dut_oe_i.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcmb_tb_host (
    input wire logic clock_i,
    input wire logic [7:0] dut_data_i,
    input wire logic dut_oe_i,
    output var rtcmb_pkg::rtcmb_bus_s bus_o
);
    initial begin
        bus_o = {1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
    end

    task automatic idle(input logic s);
        bus_o.style_ds <= s;
        bus_o.addr_strobe <= 1'b0;
        bus_o.data_strobe <= ~s;
        bus_o.dir_wr <= 1'b1;
        bus_o.cs_n <= 1'b1;
        bus_o.upper_ram_select <= 1'b0;
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Address phase, then data phase on the same lines
    task automatic access(input logic up, input logic [7:0] addr, input logic rd,
                          input logic [7:0] wdata, output logic [7:0] rdata,
                          output logic late);
        logic s;
        int k;
        s = bus_o.style_ds;
        late = 1'b0;
        rdata = 8'h00;
        @(posedge clock_i);
        bus_o.addr_strobe <= 1'b1;
        bus_o.mux_addr_data <= addr;
        bus_o.upper_ram_select <= up;
        hold(6);
        bus_o.addr_strobe <= 1'b0;
        hold(6);
        bus_o.cs_n <= 1'b0;
        bus_o.upper_ram_select <= 1'b0;
        bus_o.mux_addr_data <= rd ? ~addr : wdata;
        if (s) begin
            bus_o.dir_wr <= rd;
        end
        hold(6);
        if (rd) begin
            bus_o.data_strobe <= s;
            for (k = 0; k < 40 && dut_oe_i !== 1'b1; k++) @(negedge clock_i);
            late = dut_oe_i !== 1'b1;
            repeat (2) @(negedge clock_i);
            rdata = dut_data_i;
            @(posedge clock_i);
            bus_o.data_strobe <= ~s;
        end else if (s) begin
            bus_o.data_strobe <= 1'b1;
            hold(6);
            bus_o.data_strobe <= 1'b0;
        end else begin
            bus_o.dir_wr <= 1'b0;
            hold(6);
            bus_o.dir_wr <= 1'b1;
        end
        hold(6);
        bus_o.cs_n <= 1'b1;
        bus_o.dir_wr <= 1'b1;
        // Released lines show the inverse of the last value
        bus_o.mux_addr_data <= ~bus_o.mux_addr_data;
        hold(6);
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/*
 Self-checking bench for the clock/calendar host port.
 Assumes the host model rtcmb_tb_host and shortened wipe and second counts.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, srst, rst_n, wipe_n, sup_ok;
    logic [7:0] dq;
    logic dq_oe, irq_n, irq_oe, fco, busy;
    rtcmb_pkg::rtcmb_bus_s hbus, bus;
    int n_errors = 0;
    int n_tests = 0;

    always_comb begin
        bus = hbus;
        if (dq_oe) begin
            bus.mux_addr_data = dq;
        end
    end

    rtcmb_port #(.WIPE_CYC(50), .SEC_CYC(100)) dut (
        .clock_i(clk), .srst_i(srst), .bus_i(bus), .rst_n_i(rst_n),
        .ram_wipe_n_i(wipe_n), .supply_ok_i(sup_ok), .mux_addr_data_o(dq),
        .mux_addr_data_oe_o(dq_oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
        .fixed_clock_out_o(fco), .wipe_busy_o(busy));

    rtcmb_tb_host host (.clock_i(clk), .dut_data_i(dq), .dut_oe_i(dq_oe), .bus_o(hbus));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        n_errors++;
        give_verdict();
    endtask

    task automatic rd(input logic up, input logic [7:0] a, output logic [7:0] d);
        logic late;
        host.access(up, a, 1'b1, 8'h00, d, late);
        if (late) begin
            timeout();
        end
    endtask

    task automatic wr(input logic up, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] junk;
        logic late;
        host.access(up, a, 1'b0, d, junk, late);
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk);
        srst <= 1'b1;
        host.idle(s);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Storage and upper bank through either strobe style
    task automatic t_bus(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] d;
        wr(1'b0, a, lo);
        wr(1'b1, a, hi);
        rd(1'b0, a, d);
        check(d, lo);
        rd(1'b1, a, d);
        check(d, hi);
        $display("bus test done");
    endtask

    task automatic t_wipe();
        logic [7:0] d;
        int k;
        @(posedge clk);
        wipe_n <= 1'b0;
        repeat (30) @(posedge clk);
        wipe_n <= 1'b1;
        repeat (100) @(posedge clk);
        rd(1'b0, 8'h20, d);
        check(d, 8'hA5);
        @(posedge clk);
        wipe_n <= 1'b0;
        for (k = 0; k < 200 && busy !== 1'b1; k++) @(negedge clk);
        if (busy !== 1'b1) timeout();
        @(posedge clk);
        wipe_n <= 1'b1;
        for (k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge clk);
        if (busy !== 1'b0) timeout();
        rd(1'b0, 8'h20, d);
        check(d, rtcmb_pkg::WIPE_VAL);
        rd(1'b0, rtcmb_pkg::ADDR_CTRL_B, d);
        check(d, rtcmb_pkg::CTRL_B_RST);
        $display("wipe test done");
    endtask

    task automatic t_irq();
        logic [7:0] d;
        int k;
        // Alarm enable only: its flag rose at the first second and stays quiet after
        wr(1'b0, rtcmb_pkg::ADDR_CTRL_B, 8'h22);
        for (k = 0; k < 300 && irq_oe !== 1'b1; k++) @(negedge clk);
        if (irq_oe !== 1'b1) timeout();
        check(irq_n, 1'b0);
        rd(1'b0, rtcmb_pkg::ADDR_FLAGS, d);
        check(d & 8'hB0, 8'hB0);
        check(irq_oe, 1'b0);
        $display("interrupt test done");
    endtask

    task automatic t_rst_pin();
        logic [7:0] d;
        int k;
        wr(1'b0, rtcmb_pkg::ADDR_CTRL_B, 8'h32);
        for (k = 0; k < 300 && irq_oe !== 1'b1; k++) @(negedge clk);
        if (irq_oe !== 1'b1) timeout();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        check(irq_oe, 1'b0);
        wr(1'b0, 8'h20, 8'h33);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(1'b0, 8'h20, d);
        check(d, 8'hFF);
        rd(1'b0, rtcmb_pkg::ADDR_CTRL_B, d);
        check(d, 8'h02);
        $display("reset pin test done");
    endtask

    task automatic t_supply();
        logic [7:0] d;
        logic v;
        int n;
        @(posedge clk);
        sup_ok <= 1'b0;
        repeat (8) @(posedge clk);
        check(fco, 1'b0);
        wr(1'b0, 8'h20, 8'h44);
        @(posedge clk);
        sup_ok <= 1'b1;
        repeat (6) @(posedge clk);
        rd(1'b0, 8'h20, d);
        check(d, 8'hFF);
        v = fco;
        for (n = 0; n < 8000 && fco === v; n++) @(negedge clk);
        v = fco;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fco === v && n < 8000);
        check(n, rtcmb_pkg::FIXED_HALF_CYC);
        $display("supply test done");
    endtask

    initial begin
        srst = 1'b1;
        rst_n = 1'b1;
        wipe_n = 1'b1;
        sup_ok = 1'b1;
        do_reset(1'b1);
        t_bus(8'h20, 8'hA5, 8'h5A);
        t_wipe();
        t_irq();
        t_rst_pin();
        t_supply();
        do_reset(1'b0);
        t_bus(8'h30, 8'h5C, 8'hC3);
        give_verdict();
    end
endmodule
`default_nettype wire
